// ### rtl/tod_pkg.sv
// Shared constants for the time-of-day counter and its loader end.
package tod_pkg;

   // Register indices on the 2-bit register address.
   localparam logic [1:0] REG_INCR_PERIOD = 2'h0;
   localparam logic [1:0] REG_OFFSET_PERIOD = 2'h1;
   localparam logic [1:0] REG_ADJ_COUNT = 2'h2;
   localparam logic [1:0] REG_DRIFT = 2'h3;

   // Register data width and field positions.
   localparam int REG_W = 32;
   localparam int FRAC_LSB = 0;
   localparam int FRAC_W = 16;
   localparam int WHOLE_LSB = 16;
   localparam int WHOLE_W = 4;
   localparam int PERIOD_W = 20;
   localparam int ADJ_COUNT_W = 20;
   localparam int DRIFT_INTERVAL_LSB = 20;
   localparam int DRIFT_INTERVAL_W = 12;

   // Reset values of the period fields and of the read data.
   localparam logic [3:0] INCR_WHOLE_NS_RESET = 4'h6;
   localparam logic [15:0] INCR_FRAC_NS_RESET = 16'h6666;
   localparam logic [3:0] OFFSET_ADJ_WHOLE_NS_RESET = 4'h6;
   localparam logic [15:0] OFFSET_ADJ_FRAC_NS_RESET = 16'h6666;
   localparam logic [31:0] RDATA_RESET = 32'h00000000;

   // Timestamp layouts.
   localparam int FULL_W = 96;
   localparam int SHORT_W = 64;
   localparam int NS_W = 32;
   localparam int SEC_W = 48;
   localparam int LONG_NS_W = 48;
   localparam int FULL_NS_LSB = 16;
   localparam int FULL_SEC_LSB = 48;
   localparam int LOAD_SEC_LSB = 64;
   localparam int LOAD_SEC_W = 32;
   localparam int SHORT_NS_LSB = 16;

   // Nanoseconds in one second.
   localparam logic [31:0] NS_PER_SEC = 32'h3B9ACA00;

endpackage

// ### rtl/tod_link_if.sv
// Interface joining the time-of-day counter and its loader end.
`timescale 1ns/1ps
interface tod_link_if;
   logic [1:0] reg_addr;
   logic reg_read;
   logic reg_write;
   logic [31:0] reg_wdata;
   logic [31:0] reg_rdata;
   logic full_load_strobe;
   logic [95:0] full_load_value;
   logic short_load_strobe;
   logic [63:0] short_load_value;
   logic [95:0] stamp_full_out;
   logic [63:0] stamp_short_out;

   // The counter end.
   modport device (
      input reg_addr, reg_read, reg_write, reg_wdata,
      output reg_rdata,
      input full_load_strobe, full_load_value, short_load_strobe, short_load_value,
      output stamp_full_out, stamp_short_out
   );

   // The loader and register master end.
   modport host (
      output reg_addr, reg_read, reg_write, reg_wdata,
      input reg_rdata,
      output full_load_strobe, full_load_value, short_load_strobe, short_load_value,
      input stamp_full_out, stamp_short_out
   );
endinterface

// ### rtl/tod_step_adder.sv
// Adds one step to a nanosecond and fractional nanosecond count.
`timescale 1ns/1ps
module tod_step_adder #(
   parameter int NSW = 32,
   parameter bit WRAP = 1'b1
) (
   // Current count.
   input wire logic [NSW-1:0] ns_in,
   input wire logic [15:0] frac_in,
   // Step to add.
   input wire logic [4:0] step_ns,
   input wire logic [15:0] step_frac,
   // Next count.
   output logic [NSW-1:0] ns_out,
   output logic [15:0] frac_out,
   output logic sec_carry
);
   logic [16:0] frac_sum;
   logic [NSW:0] ns_sum;
   logic [NSW:0] ns_wrapped;

   // Fraction carries into nanoseconds, and nanoseconds wrap at one second when asked.
   always_comb begin
      frac_sum = {1'b0, frac_in} + {1'b0, step_frac};
      ns_sum = {1'b0, ns_in} + (NSW+1)'(step_ns) + (NSW+1)'(frac_sum[16]);
      ns_wrapped = ns_sum - (NSW+1)'(tod_pkg::NS_PER_SEC);
      frac_out = frac_sum[15:0];
      ns_out = ns_sum[NSW-1:0];
      sec_carry = 1'b0;
      if (WRAP && (ns_sum >= (NSW+1)'(tod_pkg::NS_PER_SEC))) begin
         ns_out = ns_wrapped[NSW-1:0];
         sec_carry = 1'b1;
      end
   end
endmodule

// ### rtl/tod_counter.sv
// Time-of-day counter end: configuration registers and the two timestamp counters.
`timescale 1ns/1ps
module tod_counter #(
   parameter logic [3:0] incr_whole_ns_reset_param = tod_pkg::INCR_WHOLE_NS_RESET,
   parameter logic [15:0] incr_frac_ns_reset_param = tod_pkg::INCR_FRAC_NS_RESET,
   parameter logic [3:0] offset_adj_whole_ns_reset_param = tod_pkg::OFFSET_ADJ_WHOLE_NS_RESET,
   parameter logic [15:0] offset_adj_frac_ns_reset_param = tod_pkg::OFFSET_ADJ_FRAC_NS_RESET
) (
   // Clock and resets.
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic csr_rst_n,
   input wire logic period_rst_n,
   // Link to the loader end.
   tod_link_if.device link
);
   typedef struct packed {
      logic [1:0] csr_rst_sync;
      logic [1:0] tk_rst_sync;
      logic [3:0] incr_whole_ns;
      logic [15:0] incr_frac_ns;
      logic [3:0] offset_adj_whole_ns;
      logic [15:0] offset_adj_frac_ns;
      logic [19:0] offset_adj_cycle_count;
      logic [19:0] drift_corr_amount;
      logic [11:0] drift_corr_interval;
      logic adj_start;
      logic [31:0] rdata;
      logic [19:0] act_incr;
      logic [19:0] act_offset;
      logic [19:0] act_drift;
      logic [11:0] act_interval;
      logic [19:0] adj_remaining;
      logic [11:0] drift_cnt;
      logic [47:0] sec;
      logic [31:0] ns;
      logic [15:0] frac;
      logic [47:0] long_ns;
      logic [15:0] long_frac;
   } state_s;

   localparam state_s RESET_STATE = '{
      incr_whole_ns: incr_whole_ns_reset_param,
      incr_frac_ns: incr_frac_ns_reset_param,
      offset_adj_whole_ns: offset_adj_whole_ns_reset_param,
      offset_adj_frac_ns: offset_adj_frac_ns_reset_param,
      act_incr: {incr_whole_ns_reset_param, incr_frac_ns_reset_param},
      act_offset: {offset_adj_whole_ns_reset_param, offset_adj_frac_ns_reset_param},
      rdata: tod_pkg::RDATA_RESET,
      default: '0
   };

   state_s q;
   state_s d;
   logic csr_clr;
   logic tk_clr;
   logic drift_fire;
   logic [19:0] period_sel;
   logic [20:0] step;
   logic [31:0] ns_next;
   logic [15:0] frac_next;
   logic sec_carry;
   logic [47:0] long_ns_next;
   logic [15:0] long_frac_next;

   // Full stamp counter step with wrap of nanoseconds into seconds.
   tod_step_adder #(
      .NSW(tod_pkg::NS_W),
      .WRAP(1'b1)
   ) u_full_add (
      .ns_in(q.ns),
      .frac_in(q.frac),
      .step_ns(step[20:16]),
      .step_frac(step[15:0]),
      .ns_out(ns_next),
      .frac_out(frac_next),
      .sec_carry(sec_carry)
   );

   // Short stamp counter step; its nanoseconds never wrap.
   tod_step_adder #(
      .NSW(tod_pkg::LONG_NS_W),
      .WRAP(1'b0)
   ) u_short_add (
      .ns_in(q.long_ns),
      .frac_in(q.long_frac),
      .step_ns(step[20:16]),
      .step_frac(step[15:0]),
      .ns_out(long_ns_next),
      .frac_out(long_frac_next),
      .sec_carry()
   );

   // Reset synchronisers, register access, staging and the counters.
   always_comb begin
      d = q;
      d.csr_rst_sync = {q.csr_rst_sync[0], csr_rst_n};
      d.tk_rst_sync = {q.tk_rst_sync[0], period_rst_n};
      csr_clr = ~q.csr_rst_sync[1];
      tk_clr = ~q.tk_rst_sync[1];
      d.adj_start = 1'b0;

      // Register writes are taken on the clk_sys edge.
      if (link.reg_write) begin
         case (link.reg_addr)
            tod_pkg::REG_INCR_PERIOD: begin
               d.incr_frac_ns = link.reg_wdata[tod_pkg::FRAC_LSB +: tod_pkg::FRAC_W];
               d.incr_whole_ns = link.reg_wdata[tod_pkg::WHOLE_LSB +: tod_pkg::WHOLE_W];
            end
            tod_pkg::REG_OFFSET_PERIOD: begin
               d.offset_adj_frac_ns = link.reg_wdata[tod_pkg::FRAC_LSB +: tod_pkg::FRAC_W];
               d.offset_adj_whole_ns = link.reg_wdata[tod_pkg::WHOLE_LSB +: tod_pkg::WHOLE_W];
            end
            tod_pkg::REG_ADJ_COUNT: begin
               d.offset_adj_cycle_count = link.reg_wdata[tod_pkg::ADJ_COUNT_W-1:0];
               d.adj_start = 1'b1;
            end
            tod_pkg::REG_DRIFT: begin
               d.drift_corr_amount = link.reg_wdata[tod_pkg::PERIOD_W-1:0];
               d.drift_corr_interval = link.reg_wdata[tod_pkg::DRIFT_INTERVAL_LSB +: tod_pkg::DRIFT_INTERVAL_W];
            end
            default: begin
               d.adj_start = 1'b0;
            end
         endcase
      end

      // A read answers on the next edge; the count register shows cycles still to adjust.
      if (link.reg_read) begin
         case (link.reg_addr)
            tod_pkg::REG_INCR_PERIOD: d.rdata = {12'h000, q.incr_whole_ns, q.incr_frac_ns};
            tod_pkg::REG_OFFSET_PERIOD: d.rdata = {12'h000, q.offset_adj_whole_ns, q.offset_adj_frac_ns};
            tod_pkg::REG_ADJ_COUNT: d.rdata = {12'h000, q.adj_remaining};
            tod_pkg::REG_DRIFT: d.rdata = {q.drift_corr_interval, q.drift_corr_amount};
            default: d.rdata = tod_pkg::RDATA_RESET;
         endcase
      end

      // Configuration reaches the counter one edge after it is stored.
      d.act_incr = {q.incr_whole_ns, q.incr_frac_ns};
      d.act_offset = {q.offset_adj_whole_ns, q.offset_adj_frac_ns};
      d.act_drift = q.drift_corr_amount;
      d.act_interval = q.drift_corr_interval;

      // Offset period runs while cycles remain; a fresh write restarts the count.
      period_sel = (q.adj_remaining != 20'h00000) ? q.act_offset : q.act_incr;
      if (q.adj_start) begin
         d.adj_remaining = q.offset_adj_cycle_count;
      end else if (q.adj_remaining != 20'h00000) begin
         d.adj_remaining = q.adj_remaining - 20'h00001;
      end

      // Drift correction fires on the last cycle of each interval; zero turns it off.
      drift_fire = (q.act_interval != 12'h000) && (q.drift_cnt == (q.act_interval - 12'h001));
      d.drift_cnt = drift_fire ? 12'h000 : q.drift_cnt + 12'h001;
      if (q.act_interval == 12'h000) begin
         d.drift_cnt = 12'h000;
      end
      step = {1'b0, period_sel} + {1'b0, (drift_fire ? q.act_drift : 20'h00000)};

      // Full counter: a load strobe wins over the increment.
      if (link.full_load_strobe) begin
         d.frac = link.full_load_value[tod_pkg::FRAC_LSB +: tod_pkg::FRAC_W];
         d.ns = link.full_load_value[tod_pkg::FULL_NS_LSB +: tod_pkg::NS_W];
         d.sec = {16'h0000, link.full_load_value[tod_pkg::LOAD_SEC_LSB +: tod_pkg::LOAD_SEC_W]};
      end else begin
         d.frac = frac_next;
         d.ns = ns_next;
         d.sec = q.sec + {47'h0, sec_carry};
      end

      // Short counter: its own load strobe wins over the increment.
      if (link.short_load_strobe) begin
         d.long_frac = link.short_load_value[tod_pkg::FRAC_LSB +: tod_pkg::FRAC_W];
         d.long_ns = link.short_load_value[tod_pkg::SHORT_NS_LSB +: tod_pkg::LONG_NS_W];
      end else begin
         d.long_frac = long_frac_next;
         d.long_ns = long_ns_next;
      end

      // Register side reset.
      if (csr_clr) begin
         d.incr_whole_ns = RESET_STATE.incr_whole_ns;
         d.incr_frac_ns = RESET_STATE.incr_frac_ns;
         d.offset_adj_whole_ns = RESET_STATE.offset_adj_whole_ns;
         d.offset_adj_frac_ns = RESET_STATE.offset_adj_frac_ns;
         d.offset_adj_cycle_count = RESET_STATE.offset_adj_cycle_count;
         d.drift_corr_amount = RESET_STATE.drift_corr_amount;
         d.drift_corr_interval = RESET_STATE.drift_corr_interval;
         d.adj_start = 1'b0;
         d.rdata = RESET_STATE.rdata;
      end

      // Timekeeping side reset.
      if (tk_clr) begin
         d.act_incr = RESET_STATE.act_incr;
         d.act_offset = RESET_STATE.act_offset;
         d.act_drift = RESET_STATE.act_drift;
         d.act_interval = RESET_STATE.act_interval;
         d.adj_remaining = RESET_STATE.adj_remaining;
         d.drift_cnt = RESET_STATE.drift_cnt;
         d.sec = RESET_STATE.sec;
         d.ns = RESET_STATE.ns;
         d.frac = RESET_STATE.frac;
         d.long_ns = RESET_STATE.long_ns;
         d.long_frac = RESET_STATE.long_frac;
      end
   end

   // State register.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         q <= RESET_STATE;
      end else begin
         q <= d;
      end
   end

   // Outputs come straight from the state flip-flops.
   assign link.reg_rdata = q.rdata;
   assign link.stamp_full_out = {q.sec, q.ns, q.frac};
   assign link.stamp_short_out = {q.long_ns, q.long_frac};
endmodule

// ### rtl/tod_loader.sv
// Loader end: register master, time loader and stamp capture.
`timescale 1ns/1ps
module tod_loader (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst,
   // Register command port.
   input wire logic cmd_valid,
   input wire logic cmd_write,
   input wire logic [1:0] cmd_addr,
   input wire logic [31:0] cmd_wdata,
   output logic rsp_valid,
   output logic [31:0] rsp_rdata,
   // Time load requests.
   input wire logic full_load_req,
   input wire logic [95:0] full_load_time,
   input wire logic short_load_req,
   input wire logic [63:0] short_load_time,
   // Captured stamps.
   output logic [95:0] stamp_full,
   output logic [63:0] stamp_short,
   // Link to the counter end.
   tod_link_if.host link
);
   typedef struct packed {
      logic [1:0] addr;
      logic rd;
      logic wr;
      logic [31:0] wdata;
      logic rd_pend;
      logic rsp_valid;
      logic [31:0] rsp_rdata;
      logic full_req_prev;
      logic short_req_prev;
      logic full_strobe;
      logic [95:0] full_value;
      logic short_strobe;
      logic [63:0] short_value;
      logic [95:0] stamp_full;
      logic [63:0] stamp_short;
   } state_s;

   state_s q;
   state_s d;

   // Commands become one-cycle requests; load requests become one-cycle strobes on their rising edge.
   always_comb begin
      d = q;
      d.rd = cmd_valid & ~cmd_write;
      d.wr = cmd_valid & cmd_write;
      if (cmd_valid) begin
         d.addr = cmd_addr;
         d.wdata = cmd_wdata;
      end
      d.rd_pend = q.rd;
      d.rsp_valid = q.rd_pend;
      if (q.rd_pend) begin
         d.rsp_rdata = link.reg_rdata;
      end
      d.full_req_prev = full_load_req;
      d.short_req_prev = short_load_req;
      d.full_strobe = full_load_req & ~q.full_req_prev;
      d.short_strobe = short_load_req & ~q.short_req_prev;
      if (full_load_req & ~q.full_req_prev) begin
         d.full_value = full_load_time;
      end
      if (short_load_req & ~q.short_req_prev) begin
         d.short_value = short_load_time;
      end
      d.stamp_full = link.stamp_full_out;
      d.stamp_short = link.stamp_short_out;
   end

   // State register.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // Outputs straight from flip-flops.
   assign link.reg_addr = q.addr;
   assign link.reg_read = q.rd;
   assign link.reg_write = q.wr;
   assign link.reg_wdata = q.wdata;
   assign link.full_load_strobe = q.full_strobe;
   assign link.full_load_value = q.full_value;
   assign link.short_load_strobe = q.short_strobe;
   assign link.short_load_value = q.short_value;
   assign rsp_valid = q.rsp_valid;
   assign rsp_rdata = q.rsp_rdata;
   assign stamp_full = q.stamp_full;
   assign stamp_short = q.stamp_short;
endmodule

// ### tb/tod_link_monitor.sv
// Concurrent checks on the link between the counter and loader ends.
`timescale 1ns/1ps
module tod_link_monitor (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic local_rst_n,
   // Register link.
   input wire logic [1:0] reg_addr,
   input wire logic reg_read,
   input wire logic [31:0] reg_rdata,
   // Load and stamp link.
   input wire logic full_load_strobe,
   input wire logic [95:0] full_load_value,
   input wire logic short_load_strobe,
   input wire logic [63:0] short_load_value,
   input wire logic [95:0] stamp_full_out,
   input wire logic [63:0] stamp_short_out
);
   logic [95:0] load_prev_q;
   logic [95:0] stamp_prev_q;
   logic [3:0] clr_hist_q;

   default clocking @(posedge clk_sys); endclocking
   // The local clears act a few edges late, so checks rest while they may still be acting.
   default disable iff (rst || !local_rst_n || (clr_hist_q != 4'h0));

   // Keeps last cycle's load value and full stamp for the relations below.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         load_prev_q <= 96'h0;
         stamp_prev_q <= 96'h0;
         clr_hist_q <= 4'hF;
      end else begin
         load_prev_q <= full_load_value;
         stamp_prev_q <= stamp_full_out;
         clr_hist_q <= {clr_hist_q[2:0], ~local_rst_n};
      end
   end

   AST_FULL_LOAD: assert property (full_load_strobe |=> stamp_full_out ==
      {16'h0000, load_prev_q[95:64], load_prev_q[47:16], load_prev_q[15:0]})
      else $error("full stamp does not show the loaded time");
   AST_SHORT_LOAD: assert property (short_load_strobe |=> stamp_short_out == $past(short_load_value))
      else $error("short stamp does not show the loaded time");
   AST_FULL_PULSE: assert property (full_load_strobe |=> !full_load_strobe)
      else $error("full load strobe longer than one cycle");
   AST_SHORT_PULSE: assert property ($rose(short_load_strobe) |=> $fell(short_load_strobe))
      else $error("short load strobe longer than one cycle");
   AST_NS_RANGE: assert property (stamp_full_out[47:16] < tod_pkg::NS_PER_SEC)
      else $error("nanosecond field reached one second");
   AST_FULL_MONO: assert property (!full_load_strobe |=> stamp_full_out >= stamp_prev_q)
      else $error("full stamp went backwards");
   AST_SEC_CARRY: assert property (!full_load_strobe ##1 (stamp_full_out[95:48] != stamp_prev_q[95:48]) |->
      stamp_full_out[95:48] == stamp_prev_q[95:48] + 48'h1 && stamp_full_out[47:16] < stamp_prev_q[47:16])
      else $error("seconds changed without a nanosecond wrap");
   AST_RDATA_HOLD: assert property (!reg_read |=> $stable(reg_rdata))
      else $error("read data changed without a read");
   AST_UPPER_ZERO: assert property (reg_read && reg_addr != tod_pkg::REG_DRIFT |=> reg_rdata[31:20] == 12'h000)
      else $error("unused register bits read nonzero");

   // Main scenarios reached.
   COV_FULL: cover property (full_load_strobe);
   COV_SHORT: cover property (short_load_strobe);
   COV_CARRY: cover property (stamp_full_out[95:48] != stamp_prev_q[95:48]);
endmodule

// ### tb/time_of_day_counter_tb.sv
// Self-checking bench joining the counter end and the loader end.
`timescale 1ns/1ps
module time_of_day_counter_tb;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic csr_rst_n = 1'b0;
   logic period_rst_n = 1'b0;
   logic cmd_valid = 1'b0;
   logic cmd_write = 1'b0;
   logic [1:0] cmd_addr = 2'h0;
   logic [31:0] cmd_wdata = 32'h0;
   logic full_load_req = 1'b0;
   logic [95:0] full_load_time = 96'h0;
   logic short_load_req = 1'b0;
   logic [63:0] short_load_time = 64'h0;
   logic rsp_valid;
   logic [31:0] rsp_rdata;
   logic [95:0] stamp_full;
   logic [63:0] stamp_short;
   int num_errors = 0;
   int cmp_count = 0;
   int cyc = 0;

   tod_link_if link();
   tod_counter tod_counter_inst (.clk_sys(clk_sys), .rst(rst), .csr_rst_n(csr_rst_n),
      .period_rst_n(period_rst_n), .link(link));
   tod_loader tod_loader_inst (.clk_sys(clk_sys), .rst(rst), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
      .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
      .full_load_req(full_load_req), .full_load_time(full_load_time), .short_load_req(short_load_req),
      .short_load_time(short_load_time), .stamp_full(stamp_full), .stamp_short(stamp_short), .link(link));
   tod_link_monitor tod_link_monitor_inst (.clk_sys(clk_sys), .rst(rst), .reg_addr(link.reg_addr),
      .reg_read(link.reg_read), .reg_rdata(link.reg_rdata), .full_load_strobe(link.full_load_strobe),
      .full_load_value(link.full_load_value), .short_load_strobe(link.short_load_strobe),
      .short_load_value(link.short_load_value), .stamp_full_out(link.stamp_full_out),
      .stamp_short_out(link.stamp_short_out), .local_rst_n(csr_rst_n && period_rst_n));

   // Clock of 100 ns and a cycle count for step arithmetic.
   always #50 clk_sys = ~clk_sys; // Both ends share this one stamp clock.
   always @(posedge clk_sys) cyc <= cyc + 1;

   // Compares one value and reports a mismatch at once.
   task automatic check(input logic [95:0] seen, input logic [95:0] exp, input string what);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   // One register command through the loader; reads wait for the answer.
   task automatic access(input logic wr, input logic [1:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      q = 32'h0;
      @(posedge clk_sys);
      cmd_valid <= 1'b1;
      cmd_write <= wr;
      cmd_addr <= a;
      cmd_wdata <= d;
      @(posedge clk_sys);
      cmd_valid <= 1'b0;
      while (!wr && rsp_valid !== 1'b1 && n < 20) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      if (n >= 20) check(96'h0, 96'h1, "read answer missing");
      q = rsp_rdata;
      repeat (2) @(posedge clk_sys);
   endtask

   // Loads a time; returns just after the edge that loaded the counter.
   task automatic load(input logic full, input logic [95:0] v);
      @(posedge clk_sys);
      if (full) begin
         full_load_time <= v;
         full_load_req <= 1'b1;
      end else begin
         short_load_time <= v[63:0];
         short_load_req <= 1'b1;
      end
      @(posedge clk_sys);
      full_load_req <= 1'b0;
      short_load_req <= 1'b0;
      @(posedge clk_sys);
      #1;
   endtask

   // Takes the short stamp and the cycle number just after an edge.
   task automatic snap(output logic [63:0] s, output int c);
      @(posedge clk_sys);
      #1;
      s = link.stamp_short_out;
      c = cyc;
   endtask

   // Expected full stamp k steps after loading v, with the one-second wrap.
   function automatic logic [95:0] adv(input logic [95:0] v, input logic [19:0] st, input int k);
      logic [47:0] s;
      logic [63:0] t;
      s = {16'h0, v[95:64]};
      t = {16'h0, v[47:16], v[15:0]};
      for (int i = 0; i < k; i++) begin
         t = t + {44'h0, st};
         if (t[63:16] >= {16'h0, tod_pkg::NS_PER_SEC}) begin
            t = t - {16'h0, tod_pkg::NS_PER_SEC, 16'h0};
            s = s + 48'h1;
         end
      end
      return {s, t[47:0]};
   endfunction

   // Prints the counts and the verdict, then stops.
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Cuts a hang short.
   initial begin
      repeat (20000) @(posedge clk_sys);
      num_errors++;
      $display("unexpected at %0t: run did not finish", $time);
      close_out();
   end

   // Main sequence.
   initial begin
      logic [31:0] rd;
      logic [31:0] d;
      logic [1:0] a;
      logic [19:0] p1;
      logic [19:0] p2;
      logic [63:0] s0;
      logic [63:0] s1;
      logic [95:0] fv;
      int c0;
      int c1;
      void'($urandom(7));
      repeat (20) @(posedge clk_sys);
      rst <= 1'b0;
      csr_rst_n <= 1'b1;
      period_rst_n <= 1'b1;
      repeat (5) @(posedge clk_sys);
      access(1'b0, tod_pkg::REG_INCR_PERIOD, 32'h0, rd);
      check(96'(rd), 96'h66666, "increment reset");
      access(1'b0, tod_pkg::REG_OFFSET_PERIOD, 32'h0, rd);
      check(96'(rd), 96'h66666, "offset reset");
      for (int i = 0; i < 9; i++) begin
         d = $urandom();
         a = (i % 3 == 2) ? tod_pkg::REG_DRIFT : 2'(i % 3);
         access(1'b1, a, d, rd);
         access(1'b0, a, 32'h0, rd);
         check(96'(rd), (a == tod_pkg::REG_DRIFT) ? 96'(d) : 96'(d[19:0]), "register readback");
      end
      access(1'b1, tod_pkg::REG_DRIFT, 32'h0, rd);
      for (int i = 0; i < 4; i++) begin
         p1 = (i == 0) ? 20'hFFFFF : (i == 3) ? 20'h80000 : 20'($urandom());
         access(1'b1, tod_pkg::REG_INCR_PERIOD, 32'(p1), rd);
         snap(s0, c0);
         snap(s1, c1);
         check(96'(s1 - s0), 96'(p1), "step per cycle");
      end
      p2 = 20'($urandom());
      access(1'b1, tod_pkg::REG_OFFSET_PERIOD, 32'(p2), rd);
      snap(s0, c0);
      access(1'b1, tod_pkg::REG_ADJ_COUNT, 32'h5, rd);
      repeat (10) @(posedge clk_sys);
      snap(s1, c1);
      check(96'(s1 - s0), 96'(64'(c1 - c0) * p1 + 64'h5 * p2 - 64'h5 * p1), "offset adjust");
      access(1'b0, tod_pkg::REG_ADJ_COUNT, 32'h0, rd);
      check(96'(rd), 96'h0, "offset count spent");
      p2 = 20'($urandom());
      access(1'b1, tod_pkg::REG_DRIFT, {12'h004, p2}, rd);
      repeat (6) @(posedge clk_sys);
      snap(s0, c0);
      repeat (39) @(posedge clk_sys);
      snap(s1, c1);
      check(96'(s1 - s0), 96'(64'(c1 - c0) * p1 + 64'((c1 - c0) / 4) * p2), "drift correction");
      access(1'b1, tod_pkg::REG_DRIFT, 32'h0, rd);
      fv = {32'($urandom()), 16'($urandom()), tod_pkg::NS_PER_SEC - 32'h3, 16'($urandom())};
      load(1'b1, fv);
      check(link.stamp_full_out, adv(fv, p1, 0), "full load");
      repeat (3) @(posedge clk_sys);
      #1;
      check(link.stamp_full_out, adv(fv, p1, 3), "second carry");
      check(stamp_full, adv(fv, p1, 2), "loader full copy");
      fv = {32'h0, 16'($urandom()), 32'($urandom()), 16'($urandom())};
      load(1'b0, fv);
      check(96'(link.stamp_short_out), 96'(fv[63:0]), "short load");
      repeat (2) @(posedge clk_sys);
      #1;
      check(96'(link.stamp_short_out), 96'(fv[63:0] + 64'h2 * p1), "short count");
      check(96'(stamp_short), 96'(fv[63:0] + 64'h1 * p1), "loader short copy");
      // Pulses both local resets mid-run; registers and counters return to their reset values.
      @(posedge clk_sys);
      csr_rst_n <= 1'b0;
      period_rst_n <= 1'b0;
      repeat (3) @(posedge clk_sys);
      csr_rst_n <= 1'b1;
      period_rst_n <= 1'b1;
      @(posedge clk_sys);
      #1;
      check(link.stamp_full_out, 96'h0, "full stamp cleared");
      check(96'(link.stamp_short_out), 96'h0, "short stamp cleared");
      p2 = {tod_pkg::INCR_WHOLE_NS_RESET, tod_pkg::INCR_FRAC_NS_RESET};
      access(1'b0, tod_pkg::REG_INCR_PERIOD, 32'h0, rd);
      check(96'(rd), 96'(p2), "increment cleared");
      snap(s0, c0);
      snap(s1, c1);
      check(96'(s1 - s0), 96'(p2), "default step after clear");
      close_out();
   end
endmodule
